// >>> design/fdcm_channel_manager.sv
// What this block does
// - A close command puts the addressed logical channel into the closed state.
// - Open, close and state query without a channel number act on the selected channel.
// - A closed channel carries no transfer and the host opens it before any access.
// - An open command sets the channel direction from its mode, read only, write only or both.
// - Read moves data from the backplane into the instrument and write moves it out.
// - Only the write-only mode is supported, read-only and read-write opens are refused.
// - The select command picks the channel later commands use, logical channel 1 at power-up.
// - The allocation query returns the list of physical channels given to the instrument.
// - Logical channel n sits on the n-th physical channel of the allocation list.
// - The state query answers closed, open, initialized, read only, write only or read-write; the code only ever stores and reports closed or write only.
// - A reported direction state means the channel is opened and initialized.
// - The selection query returns the selected logical channel, from 1 to the channel count.
// - Reset selects channel 1 and opens every closed channel.
// - The delayable source catalog and the fixed source catalog are reported apart.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fdcm_defs.svh"

module fdcm_channel_manager
  import fdcm_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`FDCM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    xfer_req,
  input  wire logic [`FDCM_CHAN_W-1:0] xfer_chan,
  input  wire logic                    xfer_write,
  output logic                         xfer_ack,
  output logic                         xfer_grant,
  output logic      [`FDCM_CHAN_W-1:0] xfer_phys
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // range check
  function automatic logic chan_ok(input fdcm_chan_t ch);
    chan_ok = (ch >= `FDCM_CHAN_ONE) && (ch <= `FDCM_NUM_CH);
  endfunction

  function automatic fdcm_idx_t chan_idx(input fdcm_chan_t ch);
    fdcm_chan_t tmp;
    tmp      = ch - `FDCM_CHAN_ONE;
    chan_idx = tmp[`FDCM_IDX_W-1:0];
  endfunction

  function automatic fdcm_chan_t phys_of(input fdcm_chan_t ch);
    case (ch)
      4'h1:    phys_of = `FDCM_PHYS_CH1;
      4'h2:    phys_of = `FDCM_PHYS_CH2;
      4'h3:    phys_of = `FDCM_PHYS_CH3;
      4'h4:    phys_of = `FDCM_PHYS_CH4;
      default: phys_of = `FDCM_PHYS_NONE;
    endcase
  endfunction

  function automatic logic dir_ok(input fdcm_chan_state_t st, input logic wr);
    case (st)
      FDCM_READ_ONLY:  dir_ok = !wr;
      FDCM_WRITE_ONLY: dir_ok = wr;
      FDCM_READ_WRITE: dir_ok = 1'b1;
      default:         dir_ok = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fdcm_fsm_t        fsm_q,      fsm_d;
  fdcm_chan_t       sel_q,      sel_d;
  logic             err_q,      err_d;
  fdcm_chan_state_t conf_q,     conf_d;
  logic             conf_vld_q, conf_vld_d;
  fdcm_idx_t        init_idx_q, init_idx_d;
  logic             xack_q,     xack_d;
  logic             xgrant_q,   xgrant_d;
  fdcm_chan_t       xphys_q,    xphys_d;
  fdcm_chan_t       xchan_q,    xchan_d;
  logic [31:0]      cmd_raw_q,  cmd_raw_d;
  logic [31:0]      prdata_q,   prdata_d;

  fdcm_mem_if mem ();

  fdcm_state_mem u_mem (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .port     (mem.mem)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic       setup;
  logic       access;
  logic       cmd_hit;
  logic       stall;
  logic       wr_ok;
  logic       mapped;
  fdcm_op_t   cmd_op;
  fdcm_mode_t cmd_mode;
  fdcm_chan_t cmd_chan;
  fdcm_chan_t cmd_target;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign cmd_hit  = access && pwrite && (paddr == `FDCM_REG_CMD);
  // A command that arrives while another is still running is held off by
  // wait states instead of being dropped.
  assign stall    = cmd_hit && (fsm_q != FDCM_S_IDLE);
  assign pready   = !stall;
  assign wr_ok    = access && pwrite && !stall;
  assign pslverr  = access && !mapped;

  assign cmd_op   = fdcm_op_t'(pwdata[`FDCM_CMD_OP_LSB +: 3]);
  assign cmd_mode = fdcm_mode_t'(pwdata[`FDCM_CMD_MODE_LSB +: 2]);
  assign cmd_chan = pwdata[`FDCM_CMD_CHAN_LSB +: `FDCM_CHAN_W];
  assign cmd_target = pwdata[`FDCM_CMD_GIVEN_BIT] ? cmd_chan : sel_q;

  always_comb begin
    case (paddr)
      `FDCM_REG_CMD, `FDCM_REG_STATUS, `FDCM_REG_SEL, `FDCM_REG_CONF,
      `FDCM_REG_ALLOC, `FDCM_REG_DEL_CAT, `FDCM_REG_FIX_CAT: mapped = 1'b1;
      default:                                              mapped = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Command and transfer sequencing
  // --------------------------------------------------------------------------
  logic err_set;

  always_comb begin
    fsm_d      = fsm_q;
    sel_d      = sel_q;
    conf_d     = conf_q;
    conf_vld_d = conf_vld_q;
    init_idx_d = init_idx_q;
    xack_d     = 1'b0;
    xgrant_d   = 1'b0;
    xphys_d    = xphys_q;
    xchan_d    = xchan_q;
    cmd_raw_d  = cmd_raw_q;
    err_set    = 1'b0;
    mem.we     = 1'b0;
    mem.waddr  = `FDCM_IDX_FIRST;
    mem.wdata  = FDCM_CLOSED;
    mem.raddr  = chan_idx(xfer_chan);

    case (fsm_q)
      FDCM_S_IDLE: begin
        if (cmd_hit && wr_ok) begin
          cmd_raw_d = pwdata;
          case (cmd_op)
            FDCM_OPC_SEL: begin
              if (chan_ok(cmd_chan)) begin
                sel_d = cmd_chan;
              end else begin
                err_set = 1'b1;
              end
            end
            FDCM_OPC_OPEN: begin
              if ((cmd_mode == FDCM_M_WO) && chan_ok(cmd_target)) begin
                mem.we    = 1'b1;
                mem.waddr = chan_idx(cmd_target);
                mem.wdata = FDCM_WRITE_ONLY;
              end else begin
                err_set = 1'b1;
              end
            end
            FDCM_OPC_CLOSE: begin
              if (chan_ok(cmd_target)) begin
                mem.we    = 1'b1;
                mem.waddr = chan_idx(cmd_target);
                mem.wdata = FDCM_CLOSED;
              end else begin
                err_set = 1'b1;
              end
            end
            FDCM_OPC_CONF: begin
              if (chan_ok(cmd_target)) begin
                mem.raddr  = chan_idx(cmd_target);
                conf_vld_d = 1'b0;
                fsm_d      = FDCM_S_CONF;
              end else begin
                err_set = 1'b1;
              end
            end
            FDCM_OPC_RST: begin
              sel_d      = `FDCM_SEL_RST;
              init_idx_d = `FDCM_IDX_FIRST;
              fsm_d      = FDCM_S_INIT;
            end
            default: begin
              err_set = 1'b1;
            end
          endcase
        end else if (xfer_req && !xack_q) begin
          xchan_d = xfer_chan;
          if (chan_ok(xfer_chan)) begin
            fsm_d = FDCM_S_XFER;
          end else begin
            // Out-of-range transfers are answered at once and refused, with no
            // physical channel shown, so a stale mapping is never reported.
            xack_d  = 1'b1;
            xphys_d = `FDCM_PHYS_NONE;
          end
        end
      end
      FDCM_S_INIT: begin
        mem.we     = 1'b1;
        mem.waddr  = init_idx_q;
        mem.wdata  = FDCM_WRITE_ONLY;
        init_idx_d = init_idx_q + 2'h1;
        if (init_idx_q == `FDCM_IDX_LAST) begin
          fsm_d = FDCM_S_IDLE;
        end
      end
      FDCM_S_CONF: begin
        conf_d     = mem.rdata;
        conf_vld_d = 1'b1;
        fsm_d      = FDCM_S_IDLE;
      end
      FDCM_S_XFER: begin
        xack_d   = 1'b1;
        xgrant_d = dir_ok(mem.rdata, xfer_write);
        xphys_d  = phys_of(xchan_q);
        fsm_d    = FDCM_S_IDLE;
      end
      default: begin
        fsm_d = FDCM_S_IDLE;
      end
    endcase

    // Error flag: a new error in the clearing cycle survives.
    err_d = err_set || (err_q && !(wr_ok && (paddr == `FDCM_REG_STATUS) && pwdata[`FDCM_STAT_ERR_BIT]));
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Read data is captured in the setup phase, so a read never needs a wait
  // state; the cost is that the value is one cycle older than the access.
  logic [31:0] alloc_word;

  assign alloc_word = {12'h000, `FDCM_NUM_CH, `FDCM_PHYS_CH4, `FDCM_PHYS_CH3,
                       `FDCM_PHYS_CH2, `FDCM_PHYS_CH1};

  always_comb begin
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      case (paddr)
        `FDCM_REG_CMD: begin
          prdata_d = cmd_raw_q;
        end
        `FDCM_REG_STATUS: begin
          prdata_d = `FDCM_WORD_ZERO;
          prdata_d[`FDCM_STAT_BUSY_BIT] = (fsm_q != FDCM_S_IDLE);
          prdata_d[`FDCM_STAT_ERR_BIT] = err_q;
          prdata_d[`FDCM_STAT_SEL_LSB +: `FDCM_CHAN_W] = sel_q;
        end
        `FDCM_REG_SEL: begin
          prdata_d = {28'h000_0000, sel_q};
        end
        `FDCM_REG_CONF: begin
          prdata_d = `FDCM_WORD_ZERO;
          prdata_d[2:0] = conf_q;
          prdata_d[`FDCM_CONF_VLD_BIT] = conf_vld_q;
        end
        `FDCM_REG_ALLOC: begin
          prdata_d = alloc_word;
        end
        `FDCM_REG_DEL_CAT: begin
          prdata_d = `FDCM_DEL_CAT_MASK;
        end
        `FDCM_REG_FIX_CAT: begin
          prdata_d = `FDCM_FIX_CAT_MASK;
        end
        default: begin
          prdata_d = `FDCM_WORD_ZERO;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Reset enters the sweep so that every channel comes up opened.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fsm_q      <= FDCM_S_INIT;
      sel_q      <= `FDCM_SEL_RST;
      err_q      <= 1'b0;
      conf_q     <= FDCM_CLOSED;
      conf_vld_q <= 1'b0;
      init_idx_q <= `FDCM_IDX_FIRST;
      xack_q     <= 1'b0;
      xgrant_q   <= 1'b0;
      xphys_q    <= `FDCM_PHYS_NONE;
      xchan_q    <= `FDCM_PHYS_NONE;
      cmd_raw_q  <= `FDCM_WORD_ZERO;
      prdata_q   <= `FDCM_WORD_ZERO;
    end else begin
      fsm_q      <= fsm_d;
      sel_q      <= sel_d;
      err_q      <= err_d;
      conf_q     <= conf_d;
      conf_vld_q <= conf_vld_d;
      init_idx_q <= init_idx_d;
      xack_q     <= xack_d;
      xgrant_q   <= xgrant_d;
      xphys_q    <= xphys_d;
      xchan_q    <= xchan_d;
      cmd_raw_q  <= cmd_raw_d;
      prdata_q   <= prdata_d;
    end
  end

  assign prdata     = prdata_q;
  assign xfer_ack   = xack_q;
  assign xfer_grant = xgrant_q;
  assign xfer_phys  = xphys_q;

endmodule

`default_nettype wire

// >>> design/fdcm_defs.svh
`ifndef FDCM_DEFS_SVH
`define FDCM_DEFS_SVH

// ----------------------------------------------------------------------------
// Channel geometry
// ----------------------------------------------------------------------------
`define FDCM_CHAN_W        4
`define FDCM_IDX_W         2
`define FDCM_NUM_CH        4'h4
`define FDCM_CHAN_ONE      4'h1
`define FDCM_SEL_RST       4'h1
`define FDCM_IDX_FIRST     2'h0
`define FDCM_IDX_LAST      2'h3

// Physical channels allocated to logical channels 1 to 4, in list order.
`define FDCM_PHYS_CH1      4'h2
`define FDCM_PHYS_CH2      4'h4
`define FDCM_PHYS_CH3      4'h6
`define FDCM_PHYS_CH4      4'h8
`define FDCM_PHYS_NONE     4'h0

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FDCM_ADDR_W        8
`define FDCM_REG_CMD       8'h00
`define FDCM_REG_STATUS    8'h04
`define FDCM_REG_SEL       8'h08
`define FDCM_REG_CONF      8'h0C
`define FDCM_REG_ALLOC     8'h10
`define FDCM_REG_DEL_CAT   8'h14
`define FDCM_REG_FIX_CAT   8'h18

// Command word fields.
`define FDCM_CMD_OP_LSB    0
`define FDCM_CMD_MODE_LSB  4
`define FDCM_CMD_CHAN_LSB  8
`define FDCM_CMD_GIVEN_BIT 12

// Status word fields.
`define FDCM_STAT_BUSY_BIT 0
`define FDCM_STAT_ERR_BIT  1
`define FDCM_STAT_SEL_LSB  8

// Configuration answer fields.
`define FDCM_CONF_VLD_BIT  8

// Allocation answer fields: four physical numbers of four bits, then count.
`define FDCM_ALLOC_CNT_LSB 16

// Source bits: 0 bus, 1 external, 2-9 backplane lines 0-7, 10-14 command
// triggers 0-4, 15 scanner, 16 dmm, 17 counter, 18 dac, 19 digital input,
// 20 digital output, 21 counter external arm, 22 hold, 23 immediate, 24 timer.
`define FDCM_DEL_CAT_MASK  32'h003F_FFFF
`define FDCM_FIX_CAT_MASK  32'h01C0_0000
`define FDCM_WORD_ZERO     32'h0000_0000

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define FDCM_ST_CLOSED     3'h0
`define FDCM_ST_OPEN       3'h1
`define FDCM_ST_INIT       3'h2
`define FDCM_ST_RO         3'h3
`define FDCM_ST_WO         3'h4
`define FDCM_ST_RW         3'h5

`define FDCM_OP_NONE       3'h0
`define FDCM_OP_SEL        3'h1
`define FDCM_OP_OPEN       3'h2
`define FDCM_OP_CLOSE      3'h3
`define FDCM_OP_CONF       3'h4
`define FDCM_OP_RST        3'h5

`define FDCM_MODE_NONE     2'h0
`define FDCM_MODE_RO       2'h1
`define FDCM_MODE_WO       2'h2
`define FDCM_MODE_RW       2'h3

`endif

// >>> design/fdcm_pkg.sv
`include "fdcm_defs.svh"

package fdcm_pkg;

  typedef logic [`FDCM_CHAN_W-1:0] fdcm_chan_t;
  typedef logic [`FDCM_IDX_W-1:0]  fdcm_idx_t;

  typedef enum logic [2:0] {
    FDCM_CLOSED      = `FDCM_ST_CLOSED,
    FDCM_OPENED      = `FDCM_ST_OPEN,
    FDCM_INITIALIZED = `FDCM_ST_INIT,
    FDCM_READ_ONLY   = `FDCM_ST_RO,
    FDCM_WRITE_ONLY  = `FDCM_ST_WO,
    FDCM_READ_WRITE  = `FDCM_ST_RW
  } fdcm_chan_state_t;

  typedef enum logic [2:0] {
    FDCM_OPC_NONE  = `FDCM_OP_NONE,
    FDCM_OPC_SEL   = `FDCM_OP_SEL,
    FDCM_OPC_OPEN  = `FDCM_OP_OPEN,
    FDCM_OPC_CLOSE = `FDCM_OP_CLOSE,
    FDCM_OPC_CONF  = `FDCM_OP_CONF,
    FDCM_OPC_RST   = `FDCM_OP_RST
  } fdcm_op_t;

  typedef enum logic [1:0] {
    FDCM_M_NONE = `FDCM_MODE_NONE,
    FDCM_M_RO   = `FDCM_MODE_RO,
    FDCM_M_WO   = `FDCM_MODE_WO,
    FDCM_M_RW   = `FDCM_MODE_RW
  } fdcm_mode_t;

  typedef enum logic [4:0] {
    FDCM_S_IDLE = 5'b00001,
    FDCM_S_INIT = 5'b00010,
    FDCM_S_CONF = 5'b00100,
    FDCM_S_XFER = 5'b01000,
    FDCM_S_SPR  = 5'b10000
  } fdcm_fsm_t;

endpackage

// >>> design/fdcm_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fdcm_mem_if;
  import fdcm_pkg::*;

  logic             we;
  fdcm_idx_t        waddr;
  fdcm_chan_state_t wdata;
  fdcm_idx_t        raddr;
  fdcm_chan_state_t rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// >>> design/fdcm_state_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdcm_defs.svh"

// ----------------------------------------------------------------------------
// Per-channel state store
// ----------------------------------------------------------------------------
// Entries carry no reset; the controller sweeps them after every reset.
module fdcm_state_mem
  import fdcm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  fdcm_mem_if.mem   port
);

  fdcm_chan_state_t entry_q [`FDCM_NUM_CH];
  fdcm_chan_state_t rdata_q;

  genvar gi;
  generate
    for (gi = 0; gi < `FDCM_NUM_CH; gi++) begin : g_entry
      always_ff @(posedge core_clk) begin
        if (port.we && (port.waddr == fdcm_idx_t'(gi))) begin
          entry_q[gi] <= port.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= FDCM_CLOSED;
    end else begin
      rdata_q <= entry_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule

`default_nettype wire

// >>> test/fdcm_xfer_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Data path requester
// ----------------------------------------------------------------------------
module fdcm_xfer_model (
  input  wire logic       core_clk,
  input  wire logic       xfer_ack,
  input  wire logic       xfer_grant,
  input  wire logic [3:0] xfer_phys,
  output var  logic       xfer_req,
  output var  logic [3:0] xfer_chan,
  output var  logic       xfer_write
);
  initial begin
    xfer_req   = 1'b0;
    xfer_chan  = 4'h0;
    xfer_write = 1'b0;
  end

  // Released lines show the inverse so a stale value is never mistaken for a live one.
  // request held whole
  task req(input logic [3:0] ch, input logic w, output logic g, output logic [3:0] p);
    int n;
    @(posedge core_clk);
    xfer_req   <= 1'b1;
    xfer_chan  <= ch;
    xfer_write <= w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (xfer_ack !== 1'b1 && n < 20);
    g = xfer_grant;
    p = xfer_phys;
    xfer_req   <= 1'b0;
    xfer_chan  <= ~ch;
    xfer_write <= ~w;
  endtask
endmodule

`default_nettype wire

// >>> test/fdcm_channel_manager_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdcm_defs.svh"

// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module fdcm_channel_manager_sva (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`FDCM_ADDR_W-1:0] paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    xfer_req,
  input wire logic [`FDCM_CHAN_W-1:0] xfer_chan,
  input wire logic                    xfer_write,
  input wire logic                    xfer_ack,
  input wire logic                    xfer_grant,
  input wire logic [`FDCM_CHAN_W-1:0] xfer_phys
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  wire mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);
  wire in_rng = (xfer_chan >= 4'h1) && (xfer_chan <= 4'h4);

  sequence rd_acc(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence ack_ok;
    xfer_ack && xfer_grant;
  endsequence

  // Only reads refresh the read data, so the zero answer is checked on reads alone.
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  alloc_word_a: assert property (rd_acc(8'h10) |-> prdata == 32'h0004_8642)
    else $error("allocation list wrong");
  del_cat_a: assert property (rd_acc(8'h14) |-> prdata == 32'h003F_FFFF)
    else $error("delayable catalog wrong");
  fix_cat_a: assert property (rd_acc(8'h18) |-> prdata == 32'h01C0_0000)
    else $error("fixed catalog wrong");
  ack_pulse_a: assert property (xfer_ack |=> !xfer_ack)
    else $error("transfer answer longer than one cycle");
  grant_ack_a: assert property (xfer_grant |-> xfer_ack)
    else $error("grant without answer");
  ack_cause_a: assert property (xfer_ack |-> $past(xfer_req))
    else $error("answer without request");
  phys_map_a: assert property (ack_ok |-> xfer_phys == {xfer_chan[2:0], 1'b0})
    else $error("logical to physical mapping wrong");
  wo_only_a: assert property (ack_ok |-> xfer_write && in_rng)
    else $error("grant for unsupported direction");
  range_refuse_a: assert property (xfer_ack && !in_rng |-> !xfer_grant && xfer_phys == 4'h0)
    else $error("out of range channel granted");
  ready_wait_a: assert property (!(penable && pwrite && paddr == 8'h00) |-> pready)
    else $error("wait state outside command write");
endmodule

bind fdcm_channel_manager fdcm_channel_manager_sva u_sva (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req),
  .xfer_chan(xfer_chan), .xfer_write(xfer_write), .xfer_ack(xfer_ack), .xfer_grant(xfer_grant),
  .xfer_phys(xfer_phys)
);

`default_nettype wire

// >>> test/fast_data_channel_manager_tb.sv
`timescale 1ns/1ps
`default_nettype none

module fast_data_channel_manager_tb;
  import fdcm_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, g;
  logic        xfer_req, xfer_write, xfer_ack, xfer_grant;
  logic [3:0]  xfer_chan, xfer_phys, p;
  int          num_errors = 0;
  int          n_checks   = 0;

  always #4 core_clk = ~core_clk;

  fdcm_channel_manager dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_req(xfer_req), .xfer_chan(xfer_chan), .xfer_write(xfer_write), .xfer_ack(xfer_ack),
    .xfer_grant(xfer_grant), .xfer_phys(xfer_phys));
  fdcm_xfer_model xm (.core_clk(core_clk), .xfer_ack(xfer_ack), .xfer_grant(xfer_grant),
    .xfer_phys(xfer_phys), .xfer_req(xfer_req), .xfer_chan(xfer_chan), .xfer_write(xfer_write));

  // ----------------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------------
  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk("pready", 32'h0000_0001, 32'h0000_0000);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Busy is polled rather than waited out, since the stall length depends on the last command.
  task cmd(input logic [2:0] op, input logic [1:0] md, input logic [3:0] ch, input logic gv);
    int n;
    apb(1'b1, 8'h00, {19'h0, gv, ch, 2'h0, md, 1'b0, op});
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
  endtask

  task conf(input logic [3:0] ch, input logic gv, input logic [2:0] st);
    cmd(3'h4, 2'h0, ch, gv);
    rdchk("conf", 8'h0C, {23'h0, 1'b1, 5'h0, st});
  endtask

  task xf(input logic [3:0] ch, input logic w, input logic eg, input logic [3:0] ep);
    xm.req(ch, w, g, p);
    chk("grant", {31'h0, eg}, {31'h0, g});
    chk("phys", {28'h0, ep}, {28'h0, p});
  endtask

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    summarize;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    cmd(3'h0, 2'h0, 4'h1, 1'b1);
    rdchk("status", 8'h04, 32'h0000_0102);
    apb(1'b1, 8'h04, 32'h0000_0002);
    rdchk("status", 8'h04, 32'h0000_0100);
    apb(1'b1, 8'h10, 32'h0000_0000);
    rdchk("alloc", 8'h10, 32'h0004_8642);
    rdchk("del_cat", 8'h14, 32'h003F_FFFF);
    rdchk("fix_cat", 8'h18, 32'h01C0_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, er});
    conf(4'h0, 1'b0, FDCM_WRITE_ONLY);
    for (int i = 1; i <= 4; i++) conf(i[3:0], 1'b1, FDCM_WRITE_ONLY);
    cmd(3'h3, 2'h0, 4'h2, 1'b1);
    conf(4'h2, 1'b1, FDCM_CLOSED);
    xf(4'h2, 1'b1, 1'b0, 4'h4);
    xf(4'h1, 1'b1, 1'b1, 4'h2);
    xf(4'h1, 1'b0, 1'b0, 4'h2);
    xf(4'h5, 1'b1, 1'b0, 4'h0);
    for (int m = 1; m <= 3; m += 2) begin
      cmd(3'h2, m[1:0], 4'h2, 1'b1);
      chk("open_err", 32'h0000_0102, rd);
      conf(4'h2, 1'b1, FDCM_CLOSED);
      apb(1'b1, 8'h04, 32'h0000_0002);
    end
    cmd(3'h2, 2'h2, 4'h2, 1'b1);
    chk("open_ok", 32'h0000_0100, rd);
    conf(4'h2, 1'b1, FDCM_WRITE_ONLY);
    xf(4'h2, 1'b1, 1'b1, 4'h4);
    cmd(3'h1, 2'h0, 4'h3, 1'b0);
    rdchk("status", 8'h04, 32'h0000_0300);
    rdchk("sel", 8'h08, 32'h0000_0003);
    cmd(3'h3, 2'h0, 4'h0, 1'b0);
    conf(4'h3, 1'b1, FDCM_CLOSED);
    conf(4'h1, 1'b1, FDCM_WRITE_ONLY);
    xf(4'h3, 1'b1, 1'b0, 4'h6);
    cmd(3'h1, 2'h0, 4'h5, 1'b0);
    chk("sel_err", 32'h0000_0302, rd);
    cmd(3'h1, 2'h0, 4'h0, 1'b1);
    chk("sel_zero", 32'h0000_0302, rd);
    apb(1'b1, 8'h04, 32'h0000_0002);
    cmd(3'h3, 2'h0, 4'h5, 1'b1);
    chk("close_err", 32'h0000_0302, rd);
    conf(4'h1, 1'b1, FDCM_WRITE_ONLY);
    apb(1'b1, 8'h04, 32'h0000_0002);
    cmd(3'h5, 2'h0, 4'h0, 1'b0);
    chk("rst_sel", 32'h0000_0100, rd);
    conf(4'h3, 1'b1, FDCM_WRITE_ONLY);
    xf(4'h4, 1'b1, 1'b1, 4'h8);
    summarize;
  end
endmodule

`default_nettype wire
